// ---- hw/rxa_pkg.sv ----
// Package for the receive alarm interrupt status block.
// Assumes one 100 MHz clock and an 8-bit register port.
package rxa_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] RXA_ADDR_CFG_STAT = 8'h10;
	localparam logic [7:0] RXA_ADDR_STAT = 8'h11;
	localparam logic [7:0] RXA_ADDR_IRQ_EN = 8'h12;
	localparam logic [7:0] RXA_ADDR_IRQ_FLAGS = 8'h13;
	localparam logic [7:0] RXA_ADDR_SEARCH_EN = 8'h14;
	localparam logic [7:0] RXA_ADDR_MODE = 8'h15;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RXA_IRQ_EN_RST = 8'h00;
	localparam logic [7:0] RXA_FLAGS_RST = 8'h00;
	localparam logic [4:0] RXA_SEARCH_EN_RST = 5'h1f;
	localparam int RXA_BIT_CP = 7;
	localparam int RXA_BIT_LOS = 6;
	localparam int RXA_BIT_AIS = 5;
	localparam int RXA_BIT_IDLE = 4;
	localparam int RXA_BIT_FERF = 3;
	localparam int RXA_BIT_AIC = 2;
	localparam int RXA_BIT_OOF = 1;
	localparam int RXA_BIT_PBIT = 0;
	localparam int RXA_CS_AIS = 7;
	localparam int RXA_CS_LOS = 6;
	localparam int RXA_CS_IDLE = 5;
	localparam int RXA_ST_FERF = 4;
	localparam int RXA_ST_AIC = 3;

	// ----------------------------------------
	// Loss-of-signal thresholds in bit periods
	// ----------------------------------------
	localparam logic [7:0] RXA_DS3_LOS_ZEROS = 8'hb4;
	localparam logic [7:0] RXA_DS3_WIN = 8'hb4;
	localparam logic [7:0] RXA_DS3_CLR_MARKS = 8'h3c;
	localparam logic [7:0] RXA_E3_LOS_ZEROS = 8'h20;
	localparam logic [7:0] RXA_E3_CLR_RUN = 8'h20;
	localparam logic [7:0] RXA_E3_ZERO_STR = 8'h04;

	// Framer state, Gray coded.
	typedef enum logic [1:0] {
		RXA_ACQ = 2'b00,
		RXA_INFRAME = 2'b01
	} rxa_frm_t;

	// Whole module state.
	typedef struct packed {
		logic [7:0] irq_en;
		logic [7:0] flags;
		logic [4:0] search_en;
		logic e3_mode;
		logic [7:0] rdata;
		logic los;
		logic [7:0] zero_run;
		logic [179:0] hist;
		logic [7:0] marks;
		logic [7:0] clr_run;
		logic aic_seen;
		rxa_frm_t frm;
		logic ais;
		logic idle;
		logic ferf;
		logic aic;
	} rxa_state_t;

endpackage : rxa_pkg

// ---- hw/rxa_alarm_irq.sv ----
// Receive alarm and error interrupt logic for one framer channel.
// Assumes the line bit, its valid strobe and framer events are synchronous.
//
// Overview of operation
// - Enable bit 2 gates AIC change interrupt
// - Enable bit 1 gates OOF change interrupt
// - Enable bit 0 gates P-bit error interrupt
// - Status bits latch events, clear on read
// - Bit 7 sets on CP-bit error
// - DS3 LOS after 180 consecutive zeros
// - DS3 LOS ends at 60 marks/180
// - E3 LOS after 32 consecutive zeros
// - E3 LOS ends: 32 bits, no 4-zero string
// - Bit 6 latches LOS edges, state shown
// - Bit 5 latches AIS edges, state shown
// - Bit 4 latches idle edges, state shown
// - Bit 3 latches FERF edges, state shown
// - Bit 2 latches on AIC value change
// - Bit 1 latches OOF and in-frame entry
// - Bit 0 sets on P-bit error
// - Five search enables, reset to ones
`timescale 1ns/1ps
module rxa_alarm_irq
	import rxa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic line_bit_vld,
	input wire logic line_bit,
	input wire logic cp_err,
	input wire logic p_err,
	input wire logic oof_declare,
	input wire logic frame_locked,
	input wire logic ais_state,
	input wire logic idle_state,
	input wire logic far_end_fail_state,
	input wire logic aic_bit,
	input wire logic aic_vld,
	output logic [4:0] parallel_search_enables,
	output logic los_state,
	output logic irq
);

	rxa_state_t s_q;
	rxa_state_t s_d;
	logic [7:0] ev;
	logic [7:0] rd_mux;
	logic flags_rd;
	logic los_set;
	logic los_clr;
	logic los_nxt;
	logic [7:0] marks_nxt;
	logic zero4;
	logic aic_chg;
	logic [179:0] hist_nxt;

	// ----------------------------------------
	// Loss-of-signal detection
	// ----------------------------------------

	// Shift history and count marks within the last 180 bits.
	always_comb begin
		hist_nxt = {s_q.hist[178:0], line_bit};
		marks_nxt = s_q.marks + {7'h00, line_bit}
			- {7'h00, s_q.hist[179]};
		zero4 = ~line_bit & ~s_q.hist[0] & ~s_q.hist[1] & ~s_q.hist[2];
	end

	// Declare and end LOS per framing mode.
	always_comb begin
		los_set = 1'b0;
		los_clr = 1'b0;
		if (line_bit_vld) begin
			if (s_q.e3_mode) begin
				los_set = ~line_bit && (s_q.zero_run + 8'h01 >= RXA_E3_LOS_ZEROS);
				los_clr = ~zero4 && (s_q.clr_run + 8'h01 >= RXA_E3_CLR_RUN);
			end else begin
				los_set = ~line_bit && (s_q.zero_run + 8'h01 >= RXA_DS3_LOS_ZEROS);
				los_clr = (marks_nxt >= RXA_DS3_CLR_MARKS);
			end
		end
		los_nxt = s_q.los ? ~los_clr : los_set;
	end

	// ----------------------------------------
	// Event collection
	// ----------------------------------------

	// AIC change is only judged once a first value has been seen.
	assign aic_chg = aic_vld && s_q.aic_seen && (aic_bit != s_q.aic);

	always_comb begin
		ev = 8'h00;
		ev[RXA_BIT_CP] = cp_err;
		ev[RXA_BIT_LOS] = los_nxt != s_q.los;
		ev[RXA_BIT_AIS] = ais_state != s_q.ais;
		ev[RXA_BIT_IDLE] = idle_state != s_q.idle;
		ev[RXA_BIT_FERF] = far_end_fail_state != s_q.ferf;
		ev[RXA_BIT_AIC] = aic_chg;
		ev[RXA_BIT_OOF] = oof_declare
			|| (frame_locked && s_q.frm == RXA_ACQ);
		ev[RXA_BIT_PBIT] = p_err;
	end

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		case (addr)
			RXA_ADDR_CFG_STAT: begin
				rd_mux[RXA_CS_AIS] = s_q.ais;
				rd_mux[RXA_CS_LOS] = s_q.los;
				rd_mux[RXA_CS_IDLE] = s_q.idle;
			end
			RXA_ADDR_STAT: begin
				rd_mux[RXA_ST_FERF] = s_q.ferf;
				rd_mux[RXA_ST_AIC] = s_q.aic;
			end
			RXA_ADDR_IRQ_EN: rd_mux = s_q.irq_en;
			RXA_ADDR_IRQ_FLAGS: rd_mux = s_q.flags;
			RXA_ADDR_SEARCH_EN: rd_mux = {3'h0, s_q.search_en};
			RXA_ADDR_MODE: rd_mux = {7'h00, s_q.e3_mode};
			default: rd_mux = 8'h00;
		endcase
	end

	assign flags_rd = rd_stb && (addr == RXA_ADDR_IRQ_FLAGS);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdata = rd_stb ? rd_mux : 8'h00;
		if (wr_stb) begin
			case (addr)
				RXA_ADDR_IRQ_EN: s_d.irq_en = wdata;
				RXA_ADDR_SEARCH_EN: s_d.search_en = wdata[4:0];
				RXA_ADDR_MODE: s_d.e3_mode = wdata[0];
				default: s_d.irq_en = s_q.irq_en;
			endcase
		end
		s_d.flags = (flags_rd ? 8'h00 : s_q.flags) | ev;
		if (line_bit_vld) begin
			s_d.hist = hist_nxt;
			s_d.marks = marks_nxt;
			s_d.zero_run = line_bit ? 8'h00 :
				(s_q.zero_run == 8'hff ? 8'hff : s_q.zero_run + 8'h01);
			s_d.clr_run = zero4 ? 8'h00 :
				(s_q.clr_run == 8'hff ? 8'hff : s_q.clr_run + 8'h01);
		end
		s_d.los = los_nxt;
		s_d.ais = ais_state;
		s_d.idle = idle_state;
		s_d.ferf = far_end_fail_state;
		if (aic_vld) begin
			s_d.aic = aic_bit;
			s_d.aic_seen = 1'b1;
		end
		case (s_q.frm)
			RXA_ACQ: if (frame_locked && !oof_declare) s_d.frm = RXA_INFRAME;
			RXA_INFRAME: if (oof_declare) s_d.frm = RXA_ACQ;
			default: s_d.frm = RXA_ACQ;
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.irq_en <= RXA_IRQ_EN_RST;
			s_q.flags <= RXA_FLAGS_RST;
			s_q.search_en <= RXA_SEARCH_EN_RST;
			s_q.frm <= RXA_ACQ;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = s_q.rdata;
	assign parallel_search_enables = s_q.search_en;
	assign los_state = s_q.los;
	assign irq = |(s_q.flags & s_q.irq_en);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence flag_read_s;
		rd_stb && addr == RXA_ADDR_IRQ_FLAGS && ev == 8'h00;
	endsequence

	a_flags_clear_read: assert property (@(posedge clk) disable iff (!rst_b)
		flag_read_s |=> s_q.flags == 8'h00)
		else $error("Flags not cleared by read.");
	a_event_kept_read: assert property (@(posedge clk) disable iff (!rst_b)
		(flags_rd && p_err) |=> s_q.flags[RXA_BIT_PBIT])
		else $error("Event lost during clearing read.");
	a_pbit_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.flags == 8'h01 && !s_q.irq_en[RXA_BIT_PBIT]) |-> !irq)
		else $error("P-bit interrupt not gated.");
	a_oof_irq_on: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.flags[RXA_BIT_OOF] && s_q.irq_en[RXA_BIT_OOF]) |-> irq)
		else $error("OOF interrupt missing.");
	a_aic_irq_on: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.flags[RXA_BIT_AIC] && s_q.irq_en[RXA_BIT_AIC]) |-> irq)
		else $error("AIC interrupt missing.");
	a_cp_err_latch: assert property (@(posedge clk) disable iff (!rst_b)
		cp_err |=> s_q.flags[RXA_BIT_CP])
		else $error("CP error not latched.");
	a_pbit_latch: assert property (@(posedge clk) disable iff (!rst_b)
		p_err |=> s_q.flags[RXA_BIT_PBIT])
		else $error("P-bit error not latched.");
	a_los_edge_flag: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.los != $past(s_q.los)) |-> s_q.flags[RXA_BIT_LOS])
		else $error("LOS change not flagged.");
	a_ds3_los_set: assert property (@(posedge clk) disable iff (!rst_b)
		(!s_q.e3_mode && line_bit_vld && !line_bit
		&& s_q.zero_run == 8'hb3) |=> s_q.los)
		else $error("DS3 LOS not declared.");
	a_e3_los_set: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.e3_mode && line_bit_vld && !line_bit
		&& s_q.zero_run == 8'h1f) |=> s_q.los)
		else $error("E3 LOS not declared.");
	a_search_en_reset: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |-> parallel_search_enables == RXA_SEARCH_EN_RST)
		else $error("Search enables wrong after reset.");

	// ----------------------------------------
	// Assertions on status views, flags, irq, LOS, framing and register writes
	// ----------------------------------------

	// A read of the configuration and status view.
	sequence cfg_read_s;
		rd_stb && addr == RXA_ADDR_CFG_STAT;
	endsequence

	// A read of the plain status view.
	sequence stat_read_s;
		rd_stb && addr == RXA_ADDR_STAT;
	endsequence

	a_pbit_irq_on: assert property (@(posedge clk)
		disable iff (!rst_b)
		(s_q.flags[RXA_BIT_PBIT] && s_q.irq_en[RXA_BIT_PBIT]) |-> irq)
		else $error("P-bit interrupt missing.");

	a_irq_no_enable: assert property (@(posedge clk)
		disable iff (!rst_b) (s_q.irq_en == 8'h00) |-> !irq)
		else $error("Interrupt raised with all enables off.");

	a_oof_latch: assert property (@(posedge clk)
		disable iff (!rst_b) oof_declare |=> s_q.flags[RXA_BIT_OOF])
		else $error("OOF declaration not latched.");

	a_lock_entry_flag: assert property (@(posedge clk)
		disable iff (!rst_b)
		(frame_locked && s_q.frm == RXA_ACQ) |=> s_q.flags[RXA_BIT_OOF])
		else $error("In-frame entry not latched.");

	a_frm_lock_enter: assert property (@(posedge clk)
		disable iff (!rst_b)
		(s_q.frm == RXA_ACQ && frame_locked && !oof_declare)
		|=> s_q.frm == RXA_INFRAME)
		else $error("Framer state did not enter in-frame.");

	a_ais_edge_flag: assert property (@(posedge clk)
		disable iff (!rst_b)
		(ais_state != s_q.ais) |=> s_q.flags[RXA_BIT_AIS])
		else $error("AIS change not flagged.");

	a_idle_edge_flag: assert property (@(posedge clk)
		disable iff (!rst_b)
		(idle_state != s_q.idle) |=> s_q.flags[RXA_BIT_IDLE])
		else $error("Idle change not flagged.");

	a_ferf_edge_flag: assert property (@(posedge clk)
		disable iff (!rst_b)
		(far_end_fail_state != s_q.ferf) |=> s_q.flags[RXA_BIT_FERF])
		else $error("FERF change not flagged.");

	a_aic_chg_flag: assert property (@(posedge clk)
		disable iff (!rst_b) aic_chg |=> s_q.flags[RXA_BIT_AIC])
		else $error("AIC change not flagged.");

	a_ais_state_shown: assert property (@(posedge clk)
		disable iff (!rst_b)
		cfg_read_s |=> rdata[RXA_CS_AIS] == $past(s_q.ais))
		else $error("AIS state not shown.");

	a_los_state_shown: assert property (@(posedge clk)
		disable iff (!rst_b)
		cfg_read_s |=> rdata[RXA_CS_LOS] == $past(s_q.los))
		else $error("LOS state not shown.");

	a_idle_state_shown: assert property (@(posedge clk)
		disable iff (!rst_b)
		cfg_read_s |=> rdata[RXA_CS_IDLE] == $past(s_q.idle))
		else $error("Idle state not shown.");

	a_ferf_state_shown: assert property (@(posedge clk)
		disable iff (!rst_b)
		stat_read_s |=> rdata[RXA_ST_FERF] == $past(s_q.ferf))
		else $error("FERF state not shown.");

	a_flag_read_data: assert property (@(posedge clk)
		disable iff (!rst_b) flags_rd |=> rdata == $past(s_q.flags))
		else $error("Flag read returned wrong data.");

	a_rdata_idle_zero: assert property (@(posedge clk)
		disable iff (!rst_b) !rd_stb |=> rdata == 8'h00)
		else $error("Read data not zero outside a read.");

	a_flags_no_write: assert property (@(posedge clk)
		disable iff (!rst_b)
		(wr_stb && addr == RXA_ADDR_IRQ_FLAGS && ev == 8'h00)
		|=> s_q.flags == $past(s_q.flags))
		else $error("Flags changed by a write.");

	a_ds3_los_clear: assert property (@(posedge clk)
		disable iff (!rst_b)
		(!s_q.e3_mode && s_q.los && line_bit_vld
		&& marks_nxt >= RXA_DS3_CLR_MARKS) |=> !s_q.los)
		else $error("DS3 LOS not ended.");

	a_e3_los_clear: assert property (@(posedge clk)
		disable iff (!rst_b)
		(s_q.e3_mode && s_q.los && line_bit_vld && line_bit
		&& s_q.clr_run == RXA_E3_CLR_RUN - 8'h01) |=> !s_q.los)
		else $error("E3 LOS not ended.");

	a_los_hold_idle: assert property (@(posedge clk)
		disable iff (!rst_b)
		!line_bit_vld |=> s_q.los == $past(s_q.los))
		else $error("LOS changed with no received bit.");

	a_search_en_write: assert property (@(posedge clk)
		disable iff (!rst_b)
		(wr_stb && addr == RXA_ADDR_SEARCH_EN)
		|=> parallel_search_enables == $past(wdata[4:0]))
		else $error("Search enables not written.");

	a_irq_en_write: assert property (@(posedge clk)
		disable iff (!rst_b)
		(wr_stb && addr == RXA_ADDR_IRQ_EN)
		|=> s_q.irq_en == $past(wdata))
		else $error("Interrupt enables not written.");

	a_cp_kept_read: assert property (@(posedge clk)
		disable iff (!rst_b)
		(flags_rd && cp_err) |=> s_q.flags[RXA_BIT_CP])
		else $error("CP error lost during clearing read.");

endmodule : rxa_alarm_irq

// ---- dv/rxa_liu_model.sv ----
// Line interface model that delivers received bits to the alarm block.
// Assumes the bench starts bursts with a one-cycle start pulse.
`timescale 1ns/1ps
module rxa_liu_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic value,
	input wire logic slow,
	input wire logic [8:0] count,
	output logic line_bit_vld,
	output logic line_bit,
	output logic busy
);
	logic [8:0] left;
	logic gap;

	// Sends count bits of one value; a slow burst skips every other cycle.
	// Between bits the data line flips so no stale value looks valid.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			left <= 9'h000;
			gap <= 1'b0;
			line_bit_vld <= 1'b0;
			line_bit <= 1'b0;
		end else begin
			line_bit_vld <= 1'b0;
			line_bit <= ~line_bit;
			gap <= ~gap;
			if (start) begin
				left <= count;
			end else if (left != 9'h000 && !(slow && gap)) begin
				line_bit_vld <= 1'b1;
				line_bit <= value;
				left <= left - 9'h001;
			end
		end
	end

	// Busy covers the start cycle so a waiter never misses a burst.
	assign busy = start || (left != 9'h000);
endmodule : rxa_liu_model

// ---- dv/rxa_alarm_irq_tb.sv ----
// Self-checking bench for the receive alarm interrupt block.
// Assumes the line model and the package are compiled first.
`timescale 1ns/1ps
module rxa_alarm_irq_tb import rxa_pkg::*;;
	logic clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0;
	logic st = 0, val = 0, slw = 0, lock = 0, aic = 0;
	logic ais = 0, idl = 0, ferf = 0;
	logic [3:0] ev = 4'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, en, f;
	logic [8:0] cnt = 9'h000;
	logic vld, lb, busy, los, irq;
	logic [4:0] pse;
	int n_mismatch = 0, compares = 0, exp_f = 0;

	// Free-running 100 MHz clock.
	initial forever #5 clk = ~clk;

	rxa_liu_model rxa_liu_model_inst (.clk(clk), .rst_b(rst_b),
		.start(st), .value(val), .slow(slw), .count(cnt),
		.line_bit_vld(vld), .line_bit(lb), .busy(busy));

	rxa_alarm_irq rxa_alarm_irq_inst (.clk(clk), .rst_b(rst_b),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .line_bit_vld(vld), .line_bit(lb),
		.cp_err(ev[1]), .p_err(ev[2]), .oof_declare(ev[3]),
		.frame_locked(lock), .ais_state(ais), .idle_state(idl),
		.far_end_fail_state(ferf), .aic_bit(aic), .aic_vld(ev[0]),
		.parallel_search_enables(pse), .los_state(los), .irq(irq));

	// ----------------------------------------
	// Bus, stimulus and compare tasks
	// ----------------------------------------
	task conclude;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd

	// Reading the flags empties the model's copy too.
	task rdf;
		rd(RXA_ADDR_IRQ_FLAGS, exp_f[7:0]);
		exp_f = 0;
	endtask : rdf

	task ev_p(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
	endtask : ev_p

	task send(input logic [8:0] n, input logic v);
		int k;
		k = 0;
		@(posedge clk);
		cnt <= n;
		val <= v;
		slw <= 1'($urandom);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		while (busy && k < 1000) begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 1000) begin
			n_mismatch++;
			conclude;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : send

	task los_chk(input logic e);
		chk("los_state", {7'h00, e}, {7'h00, los});
	endtask : los_chk

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(8591));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		chk("search_en", 8'h1f, {3'h0, pse});
		rd(RXA_ADDR_SEARCH_EN, 8'h1f);
		rd(RXA_ADDR_IRQ_EN, 8'h00);
		rdf;
		f = 8'($urandom);
		wr(RXA_ADDR_SEARCH_EN, f);
		rd(RXA_ADDR_SEARCH_EN, {3'h0, f[4:0]});
		chk("search_en", {3'h0, f[4:0]}, {3'h0, pse});
		wr(RXA_ADDR_SEARCH_EN, 8'h1f);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		wr(RXA_ADDR_IRQ_FLAGS, 8'hff);
		rdf;
		for (int i = 0; i < 8; i++) begin
			en = (i < 3) ? 8'(1 << i) : 8'($urandom);
			wr(RXA_ADDR_IRQ_EN, en);
			rd(RXA_ADDR_IRQ_EN, en);
			ev_p(4'b1110);
			exp_f = 8'h83;
			@(posedge clk);
			#1 chk("irq", {7'h00, |(en & 8'h83)}, {7'h00, irq});
			rdf;
			chk("irq", 8'h00, {7'h00, irq});
		end
		@(posedge clk);
		addr <= RXA_ADDR_IRQ_FLAGS;
		rd_stb <= 1'b1;
		ev <= 4'b0100;
		@(posedge clk);
		rd_stb <= 1'b0;
		ev <= 4'h0;
		#1 chk("rdata", 8'h00, rdata);
		exp_f = 8'h01;
		rdf;
		@(posedge clk);
		lock <= 1'b1;
		exp_f = 8'h02;
		repeat (2) @(posedge clk);
		rdf;
		@(posedge clk);
		lock <= 1'b0;
		ev_p(4'b1000);
		exp_f = 8'h02;
		rdf;
		wr(RXA_ADDR_IRQ_EN, 8'h04);
		@(posedge clk);
		aic <= 1'b1;
		ev_p(4'b0001);
		ev_p(4'b0001);
		rdf;
		@(posedge clk);
		aic <= 1'b0;
		ev_p(4'b0001);
		exp_f = 8'h04;
		@(posedge clk);
		#1 chk("irq", 8'h01, {7'h00, irq});
		rdf;
		@(posedge clk);
		ais <= 1'b1;
		idl <= 1'b1;
		ferf <= 1'b1;
		exp_f = 8'h38;
		repeat (2) @(posedge clk);
		rd(RXA_ADDR_CFG_STAT, 8'ha0);
		rd(RXA_ADDR_STAT, 8'h10);
		rdf;
		@(posedge clk);
		ais <= 1'b0;
		idl <= 1'b0;
		ferf <= 1'b0;
		exp_f = 8'h38;
		repeat (2) @(posedge clk);
		rdf;
		send(9'd179, 1'b0);
		los_chk(1'b0);
		send(9'd1, 1'b0);
		los_chk(1'b1);
		rd(RXA_ADDR_CFG_STAT, 8'h40);
		send(9'd59, 1'b1);
		los_chk(1'b1);
		send(9'd1, 1'b1);
		los_chk(1'b0);
		exp_f = 8'h40;
		rdf;
		wr(RXA_ADDR_MODE, 8'h01);
		send(9'd31, 1'b0);
		los_chk(1'b0);
		send(9'd1, 1'b0);
		los_chk(1'b1);
		send(9'd31, 1'b1);
		los_chk(1'b1);
		send(9'd1, 1'b1);
		los_chk(1'b0);
		exp_f = 8'h40;
		rdf;
		conclude;
	end

	// Watchdog in case a wait hangs outside the bounded loops.
	initial begin
		#900000;
		n_mismatch++;
		conclude;
	end
endmodule : rxa_alarm_irq_tb
